// ==== src/adc_dual_ctrl.sv ====
// Top level: pin sync, APB registers, mode decode and output pins
//
// Implementation choices: the register addresses and the APB register port.
module adc_dual_ctrl #(
  parameter int unsigned SHORT_DELAY = adc_ctrl_pkg::SHORT_DELAY_CYCLES,
  parameter int unsigned LONG_DELAY = adc_ctrl_pkg::LONG_DELAY_CYCLES,
  parameter int unsigned TUNE_LENGTH = adc_ctrl_pkg::TUNE_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Control pins, asynchronous to CLK_IN
  input wire logic FULL_POWER_DOWN_IN,
  input wire logic Q_CHANNEL_POWER_DOWN_IN,
  input wire logic TUNE_DELAY_SELECT_IN,
  input wire logic TUNE_DELAY_FLOAT_IN,
  input wire logic LAUNCH_EDGE_SELECT_IN,
  input wire logic TUNE_REQUEST_IN,
  // Converter core words, two's complement, on CLK_IN
  input wire logic [adc_ctrl_pkg::WORD_W-1:0] I_CORE_WORD_IN,
  input wire logic [adc_ctrl_pkg::WORD_W-1:0] Q_CORE_WORD_IN,
  // Output buses and forwarded clocks
  output logic [adc_ctrl_pkg::WORD_W-1:0] I_BUS_MAIN_OUT,
  output logic [adc_ctrl_pkg::WORD_W-1:0] I_BUS_DELAYED_OUT,
  output logic [adc_ctrl_pkg::WORD_W-1:0] Q_BUS_MAIN_OUT,
  output logic [adc_ctrl_pkg::WORD_W-1:0] Q_BUS_DELAYED_OUT,
  output logic I_BUS_OE_N_OUT,
  output logic Q_BUS_OE_N_OUT,
  output logic FORWARDED_DATA_CLOCK_OUT,
  output logic SECOND_FORWARDED_CLOCK_OUT,
  // Core control
  output logic TUNE_IN_PROGRESS_OUT,
  output logic I_CORE_POWER_DOWN_OUT,
  output logic Q_CORE_POWER_DOWN_OUT,
  output logic DES_ACTIVE_OUT,
  output logic DES_Q_SOURCE_OUT
);
  import adc_ctrl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] rst_pipe;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic tune_prev;
    logic tune_go;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] prdata;
  } top_reg_t;
  top_reg_t r, next_r;

  ctl_if ctl ();

  logic core_rst_n;
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_status;
  logic ext_mode;
  logic float_pin;
  logic q_pd_pin;
  logic [31:0] status_word;

  if (WORD_W != 8) begin : g_bad_width
    $error("adc_dual_ctrl: word width must be 8");
  end
  if (SHORT_DELAY < 1 || LONG_DELAY < SHORT_DELAY || TUNE_LENGTH < 2) begin : g_bad_count
    $error("adc_dual_ctrl: bad cycle counts");
  end

  // ****************************************
  // Bus decode
  // ****************************************
  assign setup_phase = PSEL_IN && !PENABLE_IN;
  assign access_phase = PSEL_IN && PENABLE_IN;
  assign hit_ctrl = (PADDR_IN == REG_CTRL);
  assign hit_status = (PADDR_IN == REG_STATUS);

  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access_phase && !(hit_ctrl || hit_status);
  assign PRDATA_OUT = r.prdata;

  // ****************************************
  // Mode decode
  // ****************************************
  assign core_rst_n = r.rst_pipe[1];
  assign ext_mode = r.ctrl[CTRL_EXT];
  assign float_pin = r.sync2[PIN_DLY_FLOAT];
  assign q_pd_pin = r.sync2[PIN_Q_PD];

  // Extended mode and a floating select pin both force the short delay
  assign ctl.short_delay = ext_mode || float_pin
    || !r.sync2[PIN_DLY_SEL];
  assign ctl.pd_request = r.sync2[PIN_FULL_PD];
  // Pin edge and register strobe both request a tune
  assign ctl.manual_pulse = (r.sync2[PIN_TUNE] && !r.tune_prev) || r.tune_go;

  assign ctl.ddr = r.ctrl[CTRL_DDR];
  assign ctl.nondemux = r.ctrl[CTRL_NODEMUX];
  assign ctl.launch_rise = r.sync2[PIN_EDGE];
  // Clocks keep running through a tune only when trim is disabled
  assign ctl.clock_stop = ctl.tune_run && !r.ctrl[CTRL_TRIM_OFF];
  assign ctl.i_word = I_CORE_WORD_IN;
  assign ctl.q_word = Q_CORE_WORD_IN;

  // Status word shows the block's own state
  assign status_word = {27'h0000000, DES_ACTIVE_OUT, ctl.delay_done,
    Q_CORE_POWER_DOWN_OUT, ctl.pd_active, ctl.tune_run};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    // Release of the internal reset needs running clock edges
    next_r.rst_pipe = {r.rst_pipe[0], 1'b1};
    next_r.sync1 = {TUNE_REQUEST_IN, LAUNCH_EDGE_SELECT_IN, TUNE_DELAY_FLOAT_IN,
      TUNE_DELAY_SELECT_IN, Q_CHANNEL_POWER_DOWN_IN, FULL_POWER_DOWN_IN};
    next_r.sync2 = r.sync1;
    next_r.tune_prev = r.sync2[PIN_TUNE];
    next_r.tune_go = 1'b0;
    if (access_phase && PWRITE_IN && hit_ctrl) begin
      next_r.ctrl = PWDATA_IN[CTRL_W-1:0];
      next_r.tune_go = PWDATA_IN[CTRL_TUNE_GO];
    end
    // Read data is loaded in setup so it is ready at the access edge
    if (setup_phase && !PWRITE_IN) begin
      if (hit_ctrl) begin
        next_r.prdata = {25'h0000000, r.ctrl};
      end else if (hit_status) begin
        next_r.prdata = status_word;
      end else begin
        next_r.prdata = 32'h00000000;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      r <= '{rst_pipe: 2'b00, sync1: '0, sync2: '0, tune_prev: 1'b0,
        tune_go: 1'b0, ctrl: CTRL_RESET, prdata: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Sequencers
  // ****************************************
  tune_sequencer #(
    .SHORT_CYCLES(SHORT_DELAY),
    .LONG_CYCLES(LONG_DELAY),
    .RUN_CYCLES(TUNE_LENGTH)
  ) u_tune (
    .clk_in(CLK_IN),
    .rst_n_in(core_rst_n),
    .ctl(ctl.cal)
  );

  word_sequencer u_words (
    .clk_in(CLK_IN),
    .rst_n_in(core_rst_n),
    .ctl(ctl.out)
  );

  // ****************************************
  // Output pins
  // ****************************************
  // Whole device down, or only the Q side; held down until reset is released
  assign I_CORE_POWER_DOWN_OUT = ctl.pd_active || !core_rst_n;
  assign Q_CORE_POWER_DOWN_OUT = ctl.pd_active || q_pd_pin || !core_rst_n;
  // Buses are released while a power-down pin holds their channel down; the reset hold leaves them driven
  assign I_BUS_OE_N_OUT = ctl.pd_active;
  assign Q_BUS_OE_N_OUT = ctl.pd_active || q_pd_pin;

  // Dual edge: a floating select pin picks the I input, extended mode picks any
  assign DES_ACTIVE_OUT = ext_mode ? r.ctrl[CTRL_DES_EN] : float_pin;
  assign DES_Q_SOURCE_OUT = ext_mode && r.ctrl[CTRL_DES_Q];

  assign TUNE_IN_PROGRESS_OUT = ctl.tune_run;
  assign I_BUS_MAIN_OUT = ctl.i_main;
  assign I_BUS_DELAYED_OUT = ctl.i_dly;
  assign Q_BUS_MAIN_OUT = ctl.q_main;
  assign Q_BUS_DELAYED_OUT = ctl.q_dly;
  // Both clocks come from the same flop, so they stay edge aligned
  assign FORWARDED_DATA_CLOCK_OUT = ctl.fclk;
  assign SECOND_FORWARDED_CLOCK_OUT = ctl.fclk && r.ctrl[CTRL_CLK2_EN];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence ctrl_write;
    setup_phase && PWRITE_IN && hit_ctrl ##1 access_phase && PWRITE_IN && hit_ctrl;
  endsequence

  chk_ctrl_write: assert property (ctrl_write |=> r.ctrl == $past(PWDATA_IN[CTRL_W-1:0]))
    else $error("control write not stored");
  chk_ext_short: assert property (ext_mode |-> ctl.short_delay)
    else $error("long delay used in extended mode");
  chk_float_des: assert property (
    !ext_mode && float_pin |-> DES_ACTIVE_OUT && !DES_Q_SOURCE_OUT && ctl.short_delay)
    else $error("floating select pin mode wrong");
  chk_bus_release: assert property (
    ctl.pd_active |-> I_BUS_OE_N_OUT && Q_BUS_OE_N_OUT)
    else $error("bus driven while powered down");
  chk_q_only_down: assert property (q_pd_pin && !ctl.pd_active && core_rst_n
    |-> !I_CORE_POWER_DOWN_OUT && Q_CORE_POWER_DOWN_OUT)
    else $error("Q-only power down wrong");
  chk_reset_hold: assert property (
    !core_rst_n |-> I_CORE_POWER_DOWN_OUT && !TUNE_IN_PROGRESS_OUT)
    else $error("core active before internal reset release");
  chk_pin_sync: assert property ($rose(FULL_POWER_DOWN_IN) ##1 FULL_POWER_DOWN_IN[*2]
    |-> ctl.pd_request)
    else $error("power down pin not seen after two flops");
  chk_tune_window: assert property (
    $rose(TUNE_IN_PROGRESS_OUT) |-> TUNE_IN_PROGRESS_OUT[*8])
    else $error("tune flag dropped early");
endmodule : adc_dual_ctrl

// ==== src/adc_ctrl_pkg.sv ====
// Shared constants for the dual converter control and output sequencing block
package adc_ctrl_pkg;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_EXT = 0;
  localparam int CTRL_DES_EN = 1;
  localparam int CTRL_DES_Q = 2;
  localparam int CTRL_DDR = 3;
  localparam int CTRL_NODEMUX = 4;
  localparam int CTRL_TRIM_OFF = 5;
  localparam int CTRL_CLK2_EN = 6;
  localparam int CTRL_TUNE_GO = 7;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // ****************************************
  // Pin indexes and timing counts
  // ****************************************
  localparam int PIN_FULL_PD = 0;
  localparam int PIN_Q_PD = 1;
  localparam int PIN_DLY_SEL = 2;
  localparam int PIN_DLY_FLOAT = 3;
  localparam int PIN_EDGE = 4;
  localparam int PIN_TUNE = 5;
  localparam int PIN_N = 6;
  localparam int WORD_W = 8;
  localparam int unsigned SHORT_DELAY_CYCLES = 256;
  localparam int unsigned LONG_DELAY_CYCLES = 8192;
  localparam int unsigned TUNE_CYCLES = 1000;
endpackage : adc_ctrl_pkg

// ==== src/ctl_if.sv ====
// Signals shared between the top and its tune and output sequencers
interface ctl_if;
  import adc_ctrl_pkg::*;
  logic short_delay, pd_request, manual_pulse;
  logic tune_run, delay_done, pd_active;
  logic ddr, nondemux, launch_rise, clock_stop;
  logic [WORD_W-1:0] i_word, q_word;
  logic [WORD_W-1:0] i_main, i_dly, q_main, q_dly;
  logic fclk;
  modport cal (input short_delay, pd_request, manual_pulse,
    output tune_run, delay_done, pd_active);
  modport out (input ddr, nondemux, launch_rise, clock_stop, i_word, q_word,
    output i_main, i_dly, q_main, q_dly, fclk);
endinterface : ctl_if

// ==== src/tune_sequencer.sv ====
// Power-up delay, tune cycle timing and power-down deferral
module tune_sequencer #(
  parameter int unsigned SHORT_CYCLES = adc_ctrl_pkg::SHORT_DELAY_CYCLES,
  parameter int unsigned LONG_CYCLES = adc_ctrl_pkg::LONG_DELAY_CYCLES,
  parameter int unsigned RUN_CYCLES = adc_ctrl_pkg::TUNE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  ctl_if.cal ctl
);
  import adc_ctrl_pkg::*;
  typedef enum logic [2:0] {ST_WAIT = 3'b001, ST_TUNE = 3'b010, ST_IDLE = 3'b100} tune_state_t;
  typedef struct packed {
    tune_state_t state;
    logic [31:0] count;
  } tune_reg_t;
  tune_reg_t r, next_r;
  logic [31:0] limit;

  if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || RUN_CYCLES < 2) begin : g_bad
    $error("tune_sequencer: bad cycle counts");
  end

  // Delay length chosen live, so a late select change still counts
  assign limit = ctl.short_delay ? SHORT_CYCLES : LONG_CYCLES;
  always_comb begin
    next_r = r;
    case (r.state)
      ST_WAIT: begin
        if (!ctl.pd_request) begin
          if (r.count + 32'd1 >= limit) begin
            next_r.state = ST_TUNE;
            next_r.count = 32'd0;
          end else begin
            next_r.count = r.count + 32'd1;
          end
        end
      end
      ST_TUNE: begin
        if (r.count == RUN_CYCLES - 1) begin
          next_r.state = ST_IDLE;
          next_r.count = 32'd0;
        end else begin
          next_r.count = r.count + 32'd1;
        end
      end
      ST_IDLE: begin
        if (ctl.manual_pulse && !ctl.pd_request) begin
          next_r.state = ST_TUNE;
        end
      end
      default: begin
        next_r.state = ST_WAIT;
        next_r.count = 32'd0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{state: ST_WAIT, count: 32'd0};
    end else begin
      r <= next_r;
    end
  end

  // Power down waits for a running tune to end
  assign ctl.tune_run = (r.state == ST_TUNE);
  assign ctl.pd_active = ctl.pd_request && (r.state != ST_TUNE);
  assign ctl.delay_done = (r.state != ST_WAIT);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_delay_frozen: assert property (
    r.state == ST_WAIT && ctl.pd_request |=> $stable(r.count))
    else $error("delay counter moved during power down");
  chk_manual_ignored: assert property (
    r.state == ST_IDLE && ctl.pd_request |=> !ctl.tune_run)
    else $error("tune started while powered down");
  chk_pd_deferred: assert property (ctl.tune_run |-> !ctl.pd_active)
    else $error("power down entered during tune");
endmodule : tune_sequencer

// ==== src/word_sequencer.sv ====
// Demultiplexing, offset binary coding and forwarded clock generation
module word_sequencer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  ctl_if.out ctl
);
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic phase;
    logic fclk;
    logic [WORD_W-1:0] i_main, i_dly, q_main, q_dly, i_hold, q_hold;
  } seq_reg_t;
  seq_reg_t r, next_r;

  // Core words are two's complement; flipping the sign bit gives offset binary
  function automatic logic [WORD_W-1:0] to_offset(input logic [WORD_W-1:0] w);
    return {~w[WORD_W-1], w[WORD_W-2:0]};
  endfunction : to_offset

  always_comb begin
    next_r = r;
    if (ctl.nondemux) begin
      // One word per clock on the main buses, clock edge per word
      next_r.i_main = to_offset(ctl.i_word);
      next_r.q_main = to_offset(ctl.q_word);
      next_r.fclk = ~r.fclk;
      next_r.phase = 1'b0;
    end else begin
      next_r.phase = ~r.phase;
      if (!r.phase) begin
        // Earlier word waits for the delayed bus
        next_r.i_hold = to_offset(ctl.i_word);
        next_r.q_hold = to_offset(ctl.q_word);
      end else begin
        next_r.i_dly = r.i_hold;
        next_r.q_dly = r.q_hold;
        next_r.i_main = to_offset(ctl.i_word);
        next_r.q_main = to_offset(ctl.q_word);
      end
      if (ctl.ddr) begin
        next_r.fclk = r.phase ? ~r.fclk : r.fclk;
      end else begin
        next_r.fclk = r.phase ? ctl.launch_rise : ~ctl.launch_rise;
      end
    end
    if (ctl.clock_stop) begin
      next_r.fclk = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ctl.i_main = r.i_main;
  assign ctl.i_dly = r.i_dly;
  assign ctl.q_main = r.q_main;
  assign ctl.q_dly = r.q_dly;
  assign ctl.fclk = r.fclk;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence ddr_steady;
    (ctl.ddr && !ctl.nondemux && !ctl.clock_stop)[*4];
  endsequence
  chk_ddr_quarter: assert property (ddr_steady |-> r.fclk != $past(r.fclk, 2))
    else $error("ddr clock not at quarter rate");
  chk_launch_edge: assert property (
    r.phase && !ctl.ddr && !ctl.nondemux && !ctl.clock_stop
    |=> r.fclk == $past(ctl.launch_rise))
    else $error("data not launched on selected edge");
  chk_delayed_bus: assert property (
    r.phase && !ctl.nondemux |=> r.i_dly == $past(r.i_hold))
    else $error("earlier word missing from delayed bus");
  chk_clock_stop: assert property (ctl.clock_stop[*2] |-> !r.fclk)
    else $error("forwarded clock ran during tune");
endmodule : word_sequencer

// ==== sim/capture_model.sv ====
// Far-side capture logic that latches words on the forwarded clock
module capture_model #(
  parameter int FLUSH = 4
) (
  input wire logic clk_in,
  input wire logic edge_in,
  input wire logic fclk_in,
  input wire logic oe_n_in,
  output int kept_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  int skip = 0;
  int kept = 0;
  assign kept_out = kept;
  // Latch on the edge opposite the launch edge, where the word is steady
  always @(posedge clk_in) begin
    last <= fclk_in;
    if (oe_n_in !== 1'b0) begin
      skip <= FLUSH;
    end else if (fclk_in !== last && fclk_in !== edge_in) begin
      // Stale pipeline words after power down are dropped, not counted
      if (skip > 0) begin
        skip <= skip - 1;
      end else begin
        kept <= kept + 1;
      end
    end
  end
endmodule : capture_model

// ==== sim/tb.sv ====
// Self-checking bench for the dual converter control and output block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;
  // Shortened counts keep the power-up waits brief
  localparam int unsigned SD = 4;
  localparam int unsigned LD = 16;
  localparam int unsigned TL = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ok;
  logic fpd = 1'b0;
  logic qpd = 1'b0;
  logic dsel = 1'b0;
  logic dflt = 1'b0;
  logic ledge = 1'b1;
  logic treq = 1'b0;
  logic [7:0] iw = 8'h00;
  logic [7:0] qw = 8'h00;
  logic [7:0] im, idl, qm, qdl, pim;
  logic ioe_n, qoe_n, fclk, fclk2, tune, ipd, qdn, des, desq;
  logic [6:0] ctrl_m = 7'h00;
  logic mon_en = 1'b0;
  logic pf = 1'b0;
  logic tp = 1'b0;
  logic [7:0] ih[$];
  logic [7:0] qh[$];
  logic [6:0] modes[8] = '{7'h40, 7'h40, 7'h48, 7'h50, 7'h43, 7'h43, 7'h53, 7'h47};
  int fails = 0, compares = 0, cyc_n = 0, t_rel = 0, t_rise = 0;
  int tlen = 0, tunes = 0, tog = 0, gap = 0, n0 = 0, kept;

  adc_dual_ctrl #(.SHORT_DELAY(SD), .LONG_DELAY(LD), .TUNE_LENGTH(TL)) dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .FULL_POWER_DOWN_IN(fpd), .Q_CHANNEL_POWER_DOWN_IN(qpd),
    .TUNE_DELAY_SELECT_IN(dsel), .TUNE_DELAY_FLOAT_IN(dflt), .LAUNCH_EDGE_SELECT_IN(ledge),
    .TUNE_REQUEST_IN(treq), .I_CORE_WORD_IN(iw), .Q_CORE_WORD_IN(qw), .I_BUS_MAIN_OUT(im),
    .I_BUS_DELAYED_OUT(idl), .Q_BUS_MAIN_OUT(qm), .Q_BUS_DELAYED_OUT(qdl),
    .I_BUS_OE_N_OUT(ioe_n), .Q_BUS_OE_N_OUT(qoe_n), .FORWARDED_DATA_CLOCK_OUT(fclk),
    .SECOND_FORWARDED_CLOCK_OUT(fclk2), .TUNE_IN_PROGRESS_OUT(tune),
    .I_CORE_POWER_DOWN_OUT(ipd), .Q_CORE_POWER_DOWN_OUT(qdn), .DES_ACTIVE_OUT(des),
    .DES_Q_SOURCE_OUT(desq));

  capture_model #(.FLUSH(4)) cap (.clk_in(clk), .edge_in(ledge), .fclk_in(fclk),
    .oe_n_in(ioe_n), .kept_out(kept));

  // ****************************************
  // Harness
  // ****************************************
  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Offset binary is two's complement with the sign bit inverted
  function automatic logic [7:0] off(input logic [7:0] w);
    return {~w[7], w[6:0]};
  endfunction : off

  // Core words change every cycle; the history keeps what each edge sampled
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    ih.push_front(iw);
    qh.push_front(qw);
    if (ih.size() > 4) begin
      void'(ih.pop_back());
      void'(qh.pop_back());
    end
    iw <= 8'($urandom);
    qw <= 8'($urandom);
    // Whole run needs about seven hundred cycles; this ceiling only catches hangs
    if (cyc_n > 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Demux buses are judged on forwarded clock edges: history on launch edges, unchanged I main bus on the others; non-demux buses every cycle
  task automatic data_check;
    ok = 1'b0;
    if (ctrl_m[CTRL_NODEMUX]) begin
      for (int k = 0; k < 2; k++) ok |= im === off(ih[k]) && qm === off(qh[k]);
      check(ok, 1'b1);
    end else if (fclk !== pf && (ctrl_m[CTRL_DDR] || fclk === ledge)) begin
      for (int k = 0; k < 3; k++) begin
        ok |= idl === off(ih[k+1]) && im === off(ih[k])
          && qdl === off(qh[k+1]) && qm === off(qh[k]);
      end
      check(ok, 1'b1);
      if (ctrl_m[CTRL_DDR] && gap > 0) check(32'(gap), 32'd2);
      gap = 0;
    end else if (fclk !== pf) begin
      check(im, pim);
    end
  endtask : data_check

  // Settled values are sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (tune === 1'b1 && tp !== 1'b1) begin
      t_rise = cyc_n;
      tunes++;
      tlen = 0;
    end
    if (tune === 1'b1) tlen++;
    if (tune === 1'b1 && tp === 1'b1 && fclk !== pf) tog++;
    if (tune !== 1'b1 && tp === 1'b1) check(32'(tlen), TL);
    if (tune === 1'b1 && tp === 1'b1 && !ctrl_m[CTRL_TRIM_OFF]) check(fclk, 1'b0);
    check(fclk2, fclk & ctrl_m[CTRL_CLK2_EN]);
    gap = mon_en ? gap + 1 : -50;
    if (mon_en) data_check();
    tp = tune;
    pf = fclk;
    pim = im;
  end

  // APB master: holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No wait count is assumed; only the run's ceiling ends a stuck transfer
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (w && a == REG_CTRL) ctrl_m = d[6:0];
    // The slave answers in its first access cycle
    check(32'(n), 32'd1);
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic restart(input logic p, input logic s, input logic f);
    @(posedge clk);
    rst_n <= 1'b0;
    fpd <= p;
    dsel <= s;
    dflt <= f;
    ctrl_m = 7'h00;
    repeat (10) @(posedge clk);
    check({ipd, qdn, tune}, 3'b110);
    rst_n <= 1'b1;
    t_rel = cyc_n;
  endtask : restart

  // Waits for the tune flag and checks how long after t_rel it came
  task automatic wait_tune(input int lo, input int up);
    int n;
    n = 0;
    while (tune !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    check(32'(t_rise - t_rel >= lo && t_rise - t_rel <= up), 32'd1);
  endtask : wait_tune

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(71));
    restart(1'b0, 1'b0, 1'b0);
    wait_tune(SD, SD + 8);
    idle(TL + 4);
    restart(1'b0, 1'b1, 1'b0);
    wait_tune(LD, LD + 8);
    idle(TL + 4);
    restart(1'b0, 1'b1, 1'b1);
    wait_tune(SD, SD + 8);
    check({des, desq}, 2'b10);
    idle(TL + 4);
    restart(1'b0, 1'b1, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_tune(SD, LD - 1);
    idle(TL + 4);
    restart(1'b1, 1'b0, 1'b0);
    idle(40);
    check({tune, ipd}, 2'b01);
    @(posedge clk);
    fpd <= 1'b0;
    t_rel = cyc_n;
    wait_tune(SD, SD + 8);
    idle(TL + 4);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h8);
    apb(1'b1, REG_CTRL, 32'habcdef40);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h40);
    apb(1'b1, REG_STATUS, 32'hff);
    check(err, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    check({err, rd[7:0]}, 9'h100);
    // Every output mode, with both launch edges in the plain demux cases
    foreach (modes[m]) begin
      @(posedge clk);
      ledge <= m[0];
      apb(1'b1, REG_CTRL, {25'h0, modes[m]});
      idle(6);
      check({des, desq}, {modes[m][1], modes[m][1] & modes[m][2]});
      mon_en = 1'b1;
      idle(40);
      mon_en = 1'b0;
    end
    @(posedge clk);
    qpd <= 1'b1;
    idle(5);
    check({ipd, qdn, ioe_n, qoe_n}, 4'b0101);
    @(posedge clk);
    qpd <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h80);
    t_rel = cyc_n;
    wait_tune(0, 8);
    @(posedge clk);
    fpd <= 1'b1;
    idle(4);
    check({tune, ipd}, 2'b10);
    idle(TL + 2);
    check({tune, ipd, ioe_n, qoe_n}, 4'b0111);
    n0 = tunes;
    apb(1'b1, REG_CTRL, 32'h80);
    @(posedge clk);
    treq <= 1'b1;
    idle(8);
    @(posedge clk);
    treq <= 1'b0;
    idle(8);
    check(32'(tunes), 32'(n0));
    @(posedge clk);
    fpd <= 1'b0;
    idle(6);
    apb(1'b1, REG_CTRL, 32'h20);
    tog = 0;
    @(posedge clk);
    treq <= 1'b1;
    t_rel = cyc_n;
    wait_tune(0, 8);
    idle(TL + 4);
    check(32'(tog > 0), 32'd1);
    check(32'(kept > 0), 32'd1);
    tally_and_finish();
  end
endmodule : tb
